/* include/wd_reset_pkg.sv */
// Constants shared by the watchdog and reset source logic
package wd_reset_pkg;
    // System clock rate in MHz (8 ns period)
    localparam int CLK_FREQ_MHZ = 125;

    // Register port geometry and offsets
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h0;
    localparam logic [ADDR_W-1:0] CONTROL_ADDR = 4'h1;

    // Status register: one flag per reset cause
    localparam int CAUSE_POR_BIT = 0;
    localparam int CAUSE_PIN_BIT = 1;
    localparam int CAUSE_DROP_BIT = 2;
    localparam int CAUSE_WD_BIT = 3;
    localparam logic [3:0] CAUSE_RESET = 4'h1;

    // Control register fields
    localparam int CTRL_IRQ_FLAG_BIT = 7;
    localparam int CTRL_IRQ_EN_BIT = 6;
    localparam int CTRL_PRESC_HI_BIT = 5;
    localparam int CTRL_UNLOCK_BIT = 4;
    localparam int CTRL_RST_EN_BIT = 3;
    localparam int CTRL_PRESC_LO_MSB = 2;
    localparam logic [3:0] PRESC_RESET = 4'h0;

    // Watchdog time-out: 2048 oscillator cycles doubled per code step
    localparam int WD_CNT_W = 20;
    localparam logic [3:0] WD_MAX_CODE = 4'h9;
    localparam logic [WD_CNT_W-1:0] WD_ALL_ONES = 20'hfffff;

    // Unlock window length in system clocks
    localparam logic [2:0] UNLOCK_CYCLES = 3'h4;

    // Times as printed units, and derived cycle counts (least times round up)
    localparam int STARTUP_DELAY_US = 4100;
    localparam int STARTUP_DELAY_CYC = STARTUP_DELAY_US * CLK_FREQ_MHZ;
    localparam int DROP_QUALIFY_NS = 2000;
    localparam int DROP_QUALIFY_CYC = (DROP_QUALIFY_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int PIN_MIN_PULSE_NS = 2500;
    localparam int PIN_MIN_PULSE_CYC = (PIN_MIN_PULSE_NS * CLK_FREQ_MHZ + 999) / 1000;

    // Synchroniser bank layout and idle values
    localparam int SYNC_W = 9;
    localparam int SY_SUPPLY_OK = 0;
    localparam int SY_PIN_RST_N = 1;
    localparam int SY_DROP_LOW = 2;
    localparam int SY_WD_OSC = 3;
    localparam int SY_PIN_DIS = 4;
    localparam int SY_ALWAYS_ON = 5;
    localparam int SY_LEVEL_LSB = 6;
    localparam logic [SYNC_W-1:0] SYNC_RST = 9'h1c2;
    localparam logic [2:0] DROP_LEVEL_OFF = 3'h7;
endpackage

/* include/qual_if.sv */
// Carrier between a level qualifier and its user
`timescale 1ns/1ps
interface qual_if;
    logic raw;
    logic enable;
    logic qualified;
    modport filter(input raw, input enable, output qualified);
    modport user(output raw, output enable, input qualified);
endinterface

/* rtl/sync_bank.sv */
// Two-stage synchroniser for a bank of asynchronous inputs
`timescale 1ns/1ps
module sync_bank #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_s;

    sync_s sync_reg;
    sync_s sync_next;

    // First stage feeds only the second stage
    always_comb begin
        sync_next = sync_reg;
        sync_next.stage1 = async_in;
        sync_next.stage2 = sync_reg.stage1;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_reg <= {RST_VAL, RST_VAL};
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg.stage2;
endmodule

/* rtl/level_qualifier.sv */
// Qualifies a level that must persist a minimum number of cycles
`timescale 1ns/1ps
module level_qualifier #(
    parameter int unsigned COUNT = 1
) (
    input wire logic clk,
    input wire logic reset_n,
    qual_if.filter bus
);
    localparam int CW = $clog2(COUNT + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic hit;
    } qual_s;

    qual_s qual_reg;
    qual_s qual_next;

    // Short glitches restart the count; release is immediate
    always_comb begin
        qual_next = qual_reg;
        if (bus.raw && bus.enable) begin
            if (qual_reg.cnt >= CW'(COUNT - 1)) begin
                qual_next.hit = 1'b1;
            end else begin
                qual_next.cnt = qual_reg.cnt + 1'b1;
            end
        end else begin
            qual_next = '0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            qual_reg <= '0;
        end else begin
            qual_reg <= qual_next;
        end
    end

    assign bus.qualified = qual_reg.hit;
endmodule

/* rtl/watchdog_reset_top.sv */
// Watchdog timer and reset source merging with start-up delay
`timescale 1ns/1ps
module watchdog_reset_top
    import wd_reset_pkg::*;
#(
    parameter int unsigned STARTUP_CYC = STARTUP_DELAY_CYC
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic wd_restart,
    input wire logic wd_irq_ack,
    input wire logic supply_ok,
    input wire logic pin_reset_n,
    input wire logic supply_drop_low,
    input wire logic wd_osc,
    input wire logic [2:0] supply_drop_level_fuse,
    input wire logic pin_reset_disable_fuse,
    input wire logic watchdog_always_on_fuse,
    input wire logic comparator_bandgap_select,
    input wire logic adc_enable,
    output logic internal_reset_n,
    output logic watchdog_irq,
    output logic bandgap_enable
);
    localparam int DELAY_W = $clog2(STARTUP_CYC + 1);

    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic [3:0] cause;
        logic irq_flag;
        logic irq_en;
        logic rst_en;
        logic [3:0] presc;
        logic [2:0] unlock_cnt;
        logic [WD_CNT_W-1:0] wd_cnt;
        logic osc_prev;
        logic wd_pulse;
        logic [DELAY_W-1:0] delay;
        logic rst_n_out;
        logic bg_out;
    } state_s;

    state_s state_reg;
    state_s state_next;

    logic [SYNC_W-1:0] sync_q;
    logic supply_low;
    logic pin_disabled;
    logic always_on;
    logic drop_enabled;
    logic rst_en_eff;
    logic irq_en_eff;
    logic [DATA_W-1:0] control_view;
    logic [DATA_W-1:0] status_view;

    qual_if pin_bus();
    qual_if drop_bus();

    // Reserved prescale codes fall back to the longest valid setting
    function automatic logic [3:0] valid_code(input logic [3:0] code);
        valid_code = (code > WD_MAX_CODE) ? WD_MAX_CODE : code;
    endfunction

    // Last count before expiry: 2048 << code, minus one
    function automatic logic [WD_CNT_W-1:0] wd_limit(input logic [3:0] code);
        logic [3:0] shift;
        shift = WD_MAX_CODE - valid_code(code);
        wd_limit = WD_ALL_ONES >> shift;
    endfunction

    // All pins and fuses cross into the system clock here
    sync_bank #(
        .WIDTH(SYNC_W),
        .RST_VAL(SYNC_RST)
    ) u_sync (
        .clk(sys_clk),
        .reset_n(reset_n),
        .async_in({supply_drop_level_fuse, watchdog_always_on_fuse, pin_reset_disable_fuse,
                   wd_osc, supply_drop_low, pin_reset_n, supply_ok}),
        .sync_out(sync_q)
    );

    // Decoded static conditions
    assign supply_low = !sync_q[SY_SUPPLY_OK];
    assign pin_disabled = sync_q[SY_PIN_DIS];
    assign always_on = sync_q[SY_ALWAYS_ON];
    assign drop_enabled = (sync_q[SY_LEVEL_LSB +: 3] != DROP_LEVEL_OFF);

    // Pin low must outlast the minimum pulse width
    assign pin_bus.raw = !sync_q[SY_PIN_RST_N];
    assign pin_bus.enable = !pin_disabled;

    level_qualifier #(
        .COUNT(PIN_MIN_PULSE_CYC)
    ) u_pin_qual (
        .clk(sys_clk),
        .reset_n(reset_n),
        .bus(pin_bus)
    );

    // Supply drops count only when they persist
    assign drop_bus.raw = sync_q[SY_DROP_LOW];
    assign drop_bus.enable = drop_enabled;

    level_qualifier #(
        .COUNT(DROP_QUALIFY_CYC)
    ) u_drop_qual (
        .clk(sys_clk),
        .reset_n(reset_n),
        .bus(drop_bus)
    );

    // Effective enables: fuse and cause flag override software
    assign rst_en_eff = state_reg.rst_en || state_reg.cause[CAUSE_WD_BIT] || always_on;
    assign irq_en_eff = state_reg.irq_en && !always_on;

    // Read views of the two registers
    always_comb begin
        control_view = '0;
        control_view[CTRL_IRQ_FLAG_BIT] = state_reg.irq_flag;
        control_view[CTRL_IRQ_EN_BIT] = irq_en_eff;
        control_view[CTRL_PRESC_HI_BIT] = state_reg.presc[3];
        control_view[CTRL_UNLOCK_BIT] = (state_reg.unlock_cnt != 3'h0);
        control_view[CTRL_RST_EN_BIT] = rst_en_eff;
        control_view[CTRL_PRESC_LO_MSB:0] = state_reg.presc[2:0];
        status_view = '0;
        status_view[3:0] = state_reg.cause;
    end

    // Next state of the whole block
    always_comb begin
        logic any_cause;
        logic osc_edge;
        logic expire;
        logic ctrl_wr;
        logic [3:0] new_presc;
        any_cause = 1'b0;
        osc_edge = 1'b0;
        expire = 1'b0;
        ctrl_wr = reg_wr && (reg_addr == CONTROL_ADDR);
        new_presc = {reg_wdata[CTRL_PRESC_HI_BIT], reg_wdata[CTRL_PRESC_LO_MSB:0]};
        state_next = state_reg;
        state_next.wd_pulse = 1'b0;
        state_next.osc_prev = sync_q[SY_WD_OSC];

        // Read data stand for one cycle only; unmapped reads give zero
        state_next.rdata = '0;
        if (reg_rd) begin
            if (reg_addr == STATUS_ADDR) begin
                state_next.rdata = status_view;
            end else if (reg_addr == CONTROL_ADDR) begin
                state_next.rdata = control_view;
            end
        end

        // Status writes: a zero clears a flag, a one leaves it
        if (reg_wr && (reg_addr == STATUS_ADDR)) begin
            state_next.cause = state_reg.cause & reg_wdata[3:0];
        end

        // Unlock window counts down and closes by itself
        if (state_reg.unlock_cnt != 3'h0) begin
            state_next.unlock_cnt = state_reg.unlock_cnt - 3'h1;
        end

        // Interrupt flag: hardware ack or write-one clears it
        if (wd_irq_ack || (ctrl_wr && reg_wdata[CTRL_IRQ_FLAG_BIT])) begin
            state_next.irq_flag = 1'b0;
        end

        // Control writes
        if (ctrl_wr) begin
            state_next.irq_en = reg_wdata[CTRL_IRQ_EN_BIT];
            if (reg_wdata[CTRL_UNLOCK_BIT] && reg_wdata[CTRL_RST_EN_BIT]) begin
                // Unlock needs both bits in one write, old value irrelevant
                state_next.unlock_cnt = UNLOCK_CYCLES;
                state_next.rst_en = 1'b1;
            end else if ((state_reg.unlock_cnt != 3'h0) && !reg_wdata[CTRL_UNLOCK_BIT]) begin
                // Inside the window: clearing and prescale change allowed
                state_next.rst_en = reg_wdata[CTRL_RST_EN_BIT];
                state_next.presc = new_presc;
                state_next.unlock_cnt = 3'h0;
            end else begin
                // Outside it the enable can only be raised
                state_next.rst_en = state_reg.rst_en || reg_wdata[CTRL_RST_EN_BIT];
            end
        end

        // Watchdog counts oscillator rising edges while enabled
        osc_edge = sync_q[SY_WD_OSC] && !state_reg.osc_prev;
        if (!(rst_en_eff || irq_en_eff)) begin
            state_next.wd_cnt = '0;
        end else if (wd_restart) begin
            state_next.wd_cnt = '0;
        end else if (osc_edge) begin
            if (state_reg.wd_cnt >= wd_limit(state_reg.presc)) begin
                // A shortened time-out expires on the next edge
                expire = 1'b1;
                state_next.wd_cnt = '0;
            end else begin
                state_next.wd_cnt = state_reg.wd_cnt + 1'b1;
            end
        end

        // Expiry action depends on the mode
        if (expire) begin
            if (always_on || !irq_en_eff) begin
                state_next.wd_pulse = 1'b1;
            end else if (rst_en_eff) begin
                state_next.irq_flag = 1'b1;
                state_next.irq_en = 1'b0;
            end else begin
                state_next.irq_flag = 1'b1;
            end
        end

        // Cause flags; hardware set wins over a software clear
        if (pin_bus.qualified) begin
            state_next.cause[CAUSE_PIN_BIT] = 1'b1;
        end
        if (drop_bus.qualified) begin
            state_next.cause[CAUSE_DROP_BIT] = 1'b1;
        end
        if (state_reg.wd_pulse) begin
            state_next.cause[CAUSE_WD_BIT] = 1'b1;
        end
        if (supply_low) begin
            state_next.cause = CAUSE_RESET;
        end

        // Merge all causes; delay counter stretches the release
        any_cause = supply_low || pin_bus.qualified || drop_bus.qualified || state_reg.wd_pulse;
        if (any_cause) begin
            state_next.delay = DELAY_W'(STARTUP_CYC);
            state_next.rst_n_out = 1'b0;
        end else if (state_reg.delay != '0) begin
            state_next.delay = state_reg.delay - 1'b1;
            state_next.rst_n_out = 1'b0;
        end else begin
            state_next.rst_n_out = 1'b1;
        end

        // Internal reset returns control to defaults; the cause flag keeps it armed
        if (!state_reg.rst_n_out) begin
            state_next.irq_flag = 1'b0;
            state_next.irq_en = 1'b0;
            state_next.rst_en = 1'b0;
            state_next.presc = PRESC_RESET;
            state_next.unlock_cnt = 3'h0;
            state_next.wd_cnt = '0;
        end

        // Bandgap reference request
        state_next.bg_out = drop_enabled || comparator_bandgap_select || adc_enable;
    end

    // Power-up: reset held and the full delay pending
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= '{
                rdata: '0,
                cause: CAUSE_RESET,
                irq_flag: 1'b0,
                irq_en: 1'b0,
                rst_en: 1'b0,
                presc: PRESC_RESET,
                unlock_cnt: 3'h0,
                wd_cnt: '0,
                osc_prev: 1'b0,
                wd_pulse: 1'b0,
                delay: DELAY_W'(STARTUP_CYC),
                rst_n_out: 1'b0,
                bg_out: 1'b0
            };
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata = state_reg.rdata;
    assign internal_reset_n = state_reg.rst_n_out;
    assign watchdog_irq = state_reg.irq_flag;
    assign bandgap_enable = state_reg.bg_out;
endmodule

/* testbench/watchdog_reset_top_properties.sv */
// Port-level checks for the watchdog and reset source block
`timescale 1ns/1ps
module wd_reset_checker
    import wd_reset_pkg::*;
#(
    parameter int unsigned STARTUP_CYC = 20
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic wd_restart,
    input wire logic wd_irq_ack,
    input wire logic supply_ok,
    input wire logic pin_reset_n,
    input wire logic wd_osc,
    input wire logic [2:0] supply_drop_level_fuse,
    input wire logic pin_reset_disable_fuse,
    input wire logic watchdog_always_on_fuse,
    input wire logic comparator_bandgap_select,
    input wire logic adc_enable,
    input wire logic internal_reset_n,
    input wire logic watchdog_irq,
    input wire logic bandgap_enable
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    logic [15:0] low_cnt;
    logic [15:0] pin_cnt;
    logic [15:0] osc_cnt;
    logic osc_d;
    wire ctrl_rd = reg_rd && reg_addr == CONTROL_ADDR;
    wire unl = reg_wr && reg_addr == CONTROL_ADDR && reg_wdata[4] && reg_wdata[3] && internal_reset_n;

    // Run lengths; raw oscillator edges can trail the synchronised ones by an edge still in flight at a restart
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            low_cnt <= 16'h0;
            pin_cnt <= 16'h0;
            osc_cnt <= 16'h0;
            osc_d <= 1'b0;
        end else begin
            low_cnt <= internal_reset_n ? 16'h0 : low_cnt + 16'h1;
            pin_cnt <= (!pin_reset_n && !pin_reset_disable_fuse) ? pin_cnt + 16'h1 : 16'h0;
            osc_cnt <= wd_restart ? 16'h0 : osc_cnt + {15'h0, wd_osc && !osc_d};
            osc_d <= wd_osc;
        end
    end

    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside the answer slot");
    AST_BANDGAP_ON: assert property ((comparator_bandgap_select || adc_enable) [*2] |-> bandgap_enable)
        else $error("bandgap off while requested");
    AST_BANDGAP_OFF: assert property ((!comparator_bandgap_select && !adc_enable &&
        supply_drop_level_fuse == DROP_LEVEL_OFF) [*5] |-> !bandgap_enable)
        else $error("bandgap on with no request");
    AST_STRETCH: assert property ($rose(internal_reset_n) |-> low_cnt >= 16'(STARTUP_CYC))
        else $error("internal reset released before the start-up delay");
    AST_SUPPLY_LOW: assert property (!supply_ok [*5] |-> !internal_reset_n)
        else $error("no reset while supply is low");
    AST_PIN_LONG: assert property (pin_cnt == 16'd330 |-> !internal_reset_n)
        else $error("long pin low did not reset");
    AST_UNLOCK_OPEN: assert property (unl ##1 !reg_wr ##1 ctrl_rd |=> reg_rdata[CTRL_UNLOCK_BIT])
        else $error("unlock bit not set inside the window");
    AST_UNLOCK_SHUT: assert property (unl ##1 !reg_wr [*6] ##1 ctrl_rd |=> !reg_rdata[CTRL_UNLOCK_BIT])
        else $error("unlock bit still set after four cycles");
    AST_ALWAYS_ON: assert property (watchdog_always_on_fuse [*4] ##1 (watchdog_always_on_fuse && ctrl_rd)
        |=> reg_rdata[CTRL_RST_EN_BIT] && !reg_rdata[CTRL_IRQ_EN_BIT])
        else $error("always-on fuse does not force reset mode");
    AST_IRQ_ACK: assert property (wd_irq_ack |=> !watchdog_irq)
        else $error("interrupt flag survives the acknowledge");
    AST_WD_MIN: assert property ($rose(watchdog_irq) |-> osc_cnt >= 16'd2046)
        else $error("watchdog expired before the shortest time-out");

    cover property ($rose(watchdog_irq));
    cover property ($fell(internal_reset_n));
    cover property (unl ##1 !reg_wr ##1 ctrl_rd);
endmodule

bind watchdog_reset_top wd_reset_checker #(.STARTUP_CYC(STARTUP_CYC)) chk_u (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wd_restart(wd_restart), .wd_irq_ack(wd_irq_ack),
    .supply_ok(supply_ok), .pin_reset_n(pin_reset_n), .wd_osc(wd_osc),
    .supply_drop_level_fuse(supply_drop_level_fuse), .pin_reset_disable_fuse(pin_reset_disable_fuse),
    .watchdog_always_on_fuse(watchdog_always_on_fuse), .comparator_bandgap_select(comparator_bandgap_select),
    .adc_enable(adc_enable), .internal_reset_n(internal_reset_n), .watchdog_irq(watchdog_irq),
    .bandgap_enable(bandgap_enable)
);

/* testbench/cpu_model.sv */
// Processor core model: register bus master, restart and acknowledge
`timescale 1ns/1ps
module cpu_model
    import wd_reset_pkg::*;
(
    input wire logic sys_clk,
    output logic [ADDR_W-1:0] reg_addr,
    output logic [DATA_W-1:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic wd_restart,
    output logic wd_irq_ack
);
    logic [15:0] exp_q[$];

    // Quiet bus at time zero
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        wd_restart = 1'b0;
        wd_irq_ack = 1'b0;
    end

    // One bus cycle; idle lines toggle so stale values are never mistaken for data
    task automatic bus(input logic w, input logic r, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= (w || r) ? a : ~reg_addr;
        reg_wdata <= w ? d : ~reg_wdata;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        bus(1'b1, 1'b0, a, d);
        bus(1'b0, 1'b0, a, d);
    endtask

    // Expected value and mask are noted before the read goes out
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] m);
        exp_q.push_back({m, e});
        bus(1'b0, 1'b1, a, 8'h00);
        bus(1'b0, 1'b0, a, 8'h00);
    endtask

    // Timed change: the new value follows the unlock write at once
    task automatic unlock(input logic [DATA_W-1:0] d);
        bus(1'b1, 1'b0, CONTROL_ADDR, 8'h18);
        bus(1'b1, 1'b0, CONTROL_ADDR, d);
        bus(1'b0, 1'b0, CONTROL_ADDR, d);
    endtask

    // Flag first: while it is set the reset enable cannot be cleared
    task automatic wd_off();
        wr(STATUS_ADDR, 8'h00);
        unlock(8'h00);
    endtask

    // One-cycle restart or interrupt acknowledge
    task automatic pulse(input logic ack);
        wd_irq_ack <= ack;
        wd_restart <= !ack;
        @(posedge sys_clk);
        wd_irq_ack <= 1'b0;
        wd_restart <= 1'b0;
        @(posedge sys_clk);
    endtask
endmodule

/* testbench/tb.sv */
// Self-checking bench for the watchdog and reset source block
`timescale 1ns/1ps
module tb;
    import wd_reset_pkg::*;
    localparam int STARTUP = 20;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, wd_restart, wd_irq_ack, internal_reset_n, watchdog_irq, bandgap_enable;
    logic supply_ok = 1'b1, pin_reset_n = 1'b1, supply_drop_low = 1'b0, wd_osc = 1'b0;
    logic [2:0] supply_drop_level_fuse = 3'h7;
    logic pin_reset_disable_fuse = 1'b0, watchdog_always_on_fuse = 1'b0;
    logic comparator_bandgap_select = 1'b0, adc_enable = 1'b0, rd_d = 1'b0;
    logic [1:0] osc_div = 2'h0;
    logic [15:0] note;
    int n_mismatch = 0, tests_run = 0, seed = 77, n = 0, rst_cycles = 0;

    watchdog_reset_top #(.STARTUP_CYC(STARTUP)) dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .wd_restart(wd_restart), .wd_irq_ack(wd_irq_ack), .supply_ok(supply_ok), .pin_reset_n(pin_reset_n),
        .supply_drop_low(supply_drop_low), .wd_osc(wd_osc), .supply_drop_level_fuse(supply_drop_level_fuse),
        .pin_reset_disable_fuse(pin_reset_disable_fuse), .watchdog_always_on_fuse(watchdog_always_on_fuse),
        .comparator_bandgap_select(comparator_bandgap_select), .adc_enable(adc_enable),
        .internal_reset_n(internal_reset_n), .watchdog_irq(watchdog_irq), .bandgap_enable(bandgap_enable));
    cpu_model cpu_u (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .wd_restart(wd_restart), .wd_irq_ack(wd_irq_ack));

    // Clock at 125 MHz
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    // Oscillator far faster than nominal so a time-out fits in a short run
    always @(posedge sys_clk) begin
        osc_div <= osc_div + 2'h1;
        wd_osc <= osc_div[1];
    end

    task automatic chk_reg(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_reg({7'h0, got}, {7'h0, exp});
    endtask

    // Read answers land one cycle after the strobe; reset cycles are tallied
    always @(posedge sys_clk) begin
        rd_d <= reg_rd;
        if (internal_reset_n === 1'b0) rst_cycles++;
        if (rd_d) begin
            note = cpu_u.exp_q.pop_front();
            chk_reg(reg_rdata & note[15:8], note[7:0] & note[15:8]);
        end
    end

    task automatic wrap_up();
        $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Bounded wait on the interrupt or the internal reset; n holds the cycles taken
    task automatic wait_for(input logic rst, input logic v, input int lim);
        n = 0;
        while ((rst ? internal_reset_n : watchdog_irq) !== v) begin
            @(posedge sys_clk);
            n++;
            if (n > lim) begin
                n_mismatch++;
                $display("unexpected at %0t: wait limit", $time);
                wrap_up();
            end
        end
    endtask

    // One cause held for dur cycles, then reset seen or not, then status read
    task automatic cause(input int k, input int dur, input logic dis, input logic exp, input logic [7:0] st);
        int r0;
        pin_reset_disable_fuse <= dis;
        repeat (4) @(posedge sys_clk);
        r0 = rst_cycles;
        case (k)
            0: supply_ok <= 1'b0;
            1: pin_reset_n <= 1'b0;
            default: supply_drop_low <= 1'b1;
        endcase
        repeat (dur) @(posedge sys_clk);
        supply_ok <= 1'b1;
        pin_reset_n <= 1'b1;
        supply_drop_low <= 1'b0;
        repeat (8) @(posedge sys_clk);
        chk_bit(rst_cycles != r0, exp);
        wait_for(1'b1, 1'b1, 100);
        cpu_u.rd(STATUS_ADDR, st, 8'hff);
    endtask

    initial begin
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        wait_for(1'b1, 1'b1, 100);
        chk_bit(n >= STARTUP, 1'b1);
        cpu_u.rd(STATUS_ADDR, CAUSE_RESET, 8'hff);
        cpu_u.wr(STATUS_ADDR, 8'h00);
        cpu_u.wr(4'h7, 8'hff);
        cpu_u.rd(4'h7, 8'h00, 8'hff);
        cpu_u.rd(STATUS_ADDR, 8'h00, 8'hff);
        for (int i = 0; i < 8; i++) begin
            comparator_bandgap_select <= 1'($random(seed));
            adc_enable <= 1'($random(seed));
            pin_reset_n <= 1'($random(seed));
            supply_drop_low <= 1'($random(seed));
            pin_reset_disable_fuse <= 1'($random(seed));
            supply_drop_level_fuse <= i[0] ? 3'h7 : 3'($random(seed));
            repeat (6) @(posedge sys_clk);
            chk_bit(bandgap_enable, comparator_bandgap_select | adc_enable | (supply_drop_level_fuse != 3'h7));
            chk_bit(internal_reset_n, 1'b1);
        end
        comparator_bandgap_select <= 1'b0;
        adc_enable <= 1'b0;
        pin_reset_n <= 1'b1;
        supply_drop_low <= 1'b0;
        pin_reset_disable_fuse <= 1'b0;
        cpu_u.wr(CONTROL_ADDR, 8'h18);
        cpu_u.rd(CONTROL_ADDR, 8'h18, 8'hff);
        repeat (3) @(posedge sys_clk);
        cpu_u.rd(CONTROL_ADDR, 8'h08, 8'hff);
        cpu_u.wr(CONTROL_ADDR, 8'h01);
        cpu_u.rd(CONTROL_ADDR, 8'h08, 8'hff);
        cpu_u.unlock(8'h02);
        cpu_u.rd(CONTROL_ADDR, 8'h02, 8'hff);
        cpu_u.unlock(8'h00);
        cpu_u.wr(CONTROL_ADDR, 8'h40);
        cpu_u.pulse(1'b0);
        repeat (5000) @(posedge sys_clk);
        cpu_u.pulse(1'b0);
        wait_for(1'b0, 1'b1, 9000);
        chk_bit(n > 8180 && n < 8215, 1'b1);
        cpu_u.rd(CONTROL_ADDR, 8'hc0, 8'hff);
        cpu_u.pulse(1'b1);
        chk_bit(watchdog_irq, 1'b0);
        cpu_u.wr(CONTROL_ADDR, 8'h48);
        cpu_u.pulse(1'b0);
        wait_for(1'b0, 1'b1, 9000);
        cpu_u.rd(CONTROL_ADDR, 8'h88, 8'hff);
        cpu_u.pulse(1'b1);
        wait_for(1'b1, 1'b0, 9000);
        chk_bit(n > 8000, 1'b1);
        wait_for(1'b1, 1'b1, 100);
        chk_bit(n >= STARTUP - 2, 1'b1);
        cpu_u.rd(STATUS_ADDR, 8'h08, 8'hff);
        cpu_u.rd(CONTROL_ADDR, 8'h08, 8'hff);
        cpu_u.wd_off();
        cpu_u.rd(CONTROL_ADDR, 8'h00, 8'hff);
        cause(1, 400, 1'b0, 1'b1, 8'h02);
        cause(1, 200, 1'b0, 1'b0, 8'h02);
        cause(1, 400, 1'b1, 1'b0, 8'h02);
        supply_drop_level_fuse <= 3'h0;
        cause(2, 320, 1'b0, 1'b1, 8'h06);
        cause(2, 150, 1'b0, 1'b0, 8'h06);
        cause(0, 5, 1'b0, 1'b1, 8'h01);
        watchdog_always_on_fuse <= 1'b1;
        repeat (4) @(posedge sys_clk);
        cpu_u.wr(CONTROL_ADDR, 8'h40);
        cpu_u.rd(CONTROL_ADDR, 8'h08, 8'h48);
        cpu_u.pulse(1'b0);
        wait_for(1'b1, 1'b0, 9000);
        chk_bit(n > 8000, 1'b1);
        wrap_up();
    end
endmodule
